// [edge_count_input_interrupt.sv]
// edge_count_input_interrupt: eight counter-mode input interrupts
// assumes: pins are asynchronous; command and set values come from core_clk logic
`timescale 1ns/10ps
`default_nettype none
module edge_count_input_interrupt
#(
    parameter bit REDUCED_IO = 1'b0
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // mask-set command strobe
    input wire logic cmd_valid,
    input wire edge_count_pkg::mask_cmd_t cmd,
    // set values, 16 bits per input
    input wire logic [127:0] set_values,
    // interrupt input pins
    input wire logic [7:0] irq_pins,
    // results
    output logic [127:0] present_values,
    output edge_count_pkg::task_req_t task_req,
    output logic cmd_error
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [7:0] pin_meta;
    logic [7:0] pin_sync;

    // two flops per pin, cleared low (the idle level) so reset leaves no false edge
    // only the second stage is read by the channels
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end
        else if (clk_en)
        begin
            pin_meta <= irq_pins;
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode and configuration latches

    logic [7:0] edge_fall;
    logic [7:0] count_up;
    logic [7:0] enable;
    logic [7:0] restart;
    logic [7:0] next_edge_fall;
    logic [7:0] next_count_up;
    logic [7:0] next_enable;
    logic [7:0] next_restart;
    logic next_cmd_error;

    // true when the input exists on this variant
    function automatic logic input_present(input logic [2:0] idx);
        input_present = !(REDUCED_IO && (idx == 3'h2 || idx == 3'h3)); // R9
    endfunction

    // distance of a selector from the first code of its group
    function automatic logic [7:0] sel_offset(input logic [7:0] sel, input logic [7:0] base);
        sel_offset = sel - base;
    endfunction

    // offset names one of the eight inputs and that input exists here
    function automatic logic sel_hits(input logic [7:0] off);
        sel_hits = (off < 8'h08) && input_present(off[2:0]);
    endfunction

    // operand starts counting, down or up
    function automatic logic op_is_start(input logic [15:0] op);
        op_is_start = (op == edge_count_pkg::OP_START_DOWN)
            || (op == edge_count_pkg::OP_START_UP);
    endfunction

    // decode one command per taken edge; a selector below its base wraps high and misses
    // a refused command leaves every setting alone, except a bad enable operand
    always_comb
    begin
        logic [7:0] edge_off;
        logic [7:0] en_off;
        edge_off = sel_offset(cmd.selector, edge_count_pkg::SEL_EDGE_BASE);
        en_off = sel_offset(cmd.selector, edge_count_pkg::SEL_ENABLE_BASE);
        next_edge_fall = edge_fall;
        next_count_up = count_up;
        next_enable = enable;
        next_restart = 8'h00;
        next_cmd_error = 1'b0;
        if (cmd_valid) // R1
        begin
            if (sel_hits(edge_off))
            begin
                // edge choice held until changed
                if (cmd.operand == edge_count_pkg::OP_EDGE_RISE) // R10
                    next_edge_fall[edge_off[2:0]] = 1'b0; // R2
                else if (cmd.operand == edge_count_pkg::OP_EDGE_FALL)
                    next_edge_fall[edge_off[2:0]] = 1'b1;
                else
                    next_cmd_error = 1'b1;
            end
            else if (sel_hits(en_off))
            begin
                if (op_is_start(cmd.operand)) // R10
                begin
                    next_enable[en_off[2:0]] = 1'b1; // R2
                    next_count_up[en_off[2:0]] = cmd.operand[0]; // R12
                    next_restart[en_off[2:0]] = 1'b1;
                end
                else
                begin
                    next_enable[en_off[2:0]] = 1'b0;
                    next_cmd_error = 1'b1;
                end
            end
            else
            begin
                next_cmd_error = 1'b1; // R9
            end
        end
    end

    // settings stay latched until the next command or a reset
    // restart is a one-cycle pulse toward the channel
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_fall <= {8{edge_count_pkg::RST_EDGE_FALL}}; // R4
            count_up <= {8{edge_count_pkg::RST_COUNT_UP}};
            enable <= {8{edge_count_pkg::RST_ENABLE}};
            restart <= 8'h00;
            cmd_error <= 1'b0;
        end
        else if (clk_en)
        begin
            edge_fall <= next_edge_fall;
            count_up <= next_count_up;
            enable <= next_enable;
            restart <= next_restart;
            cmd_error <= next_cmd_error;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counting channels

    logic [7:0] hit;

    // one channel per input
    // absent inputs of the reduced variant are never enabled, so they stay idle
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_ch
            edge_channel u_ch
            (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .edge_fall(edge_fall[gi]),
                .count_up(count_up[gi]),
                .enable(enable[gi]),
                .restart(restart[gi]),
                .set_value(set_values[gi*16 +: 16]), // R14
                .pin_sync(pin_sync[gi]),
                .present(present_values[gi*16 +: 16]), // R14
                .hit(hit[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // task dispatch: pending hits served lowest input first, one per cycle

    logic [7:0] pending;
    logic [7:0] next_pending;
    edge_count_pkg::task_req_t next_task_req;

    // lowest input first, one task per cycle
    // a fresh hit on the input being served stays queued, so neither hit is lost
    always_comb
    begin
        logic [7:0] work;
        logic found;
        work = pending | hit;
        found = 1'b0;
        next_pending = work;
        next_task_req = '0;
        for (int i = 0; i < 8; i++)
        begin
            if (!found && work[i])
            begin
                found = 1'b1;
                next_pending[i] = pending[i] & hit[i];
                next_task_req.valid = 1'b1;
                next_task_req.task_num = edge_count_pkg::TASK_BASE + 8'(i); // R7
            end
        end
    end

    // queue of waiting hits and the task request
    // the request is a registered one-cycle pulse
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending <= 8'h00;
            task_req <= '0;
        end
        else if (clk_en)
        begin
            pending <= next_pending;
            task_req <= next_task_req;
        end
    end

endmodule // edge_count_input_interrupt
`default_nettype wire

// [edge_count_pkg.sv]
// edge_count_pkg: constants and carriers for the counter-mode input interrupt unit
// assumes: single clock domain, one command strobe from the controlling program
//
// Functional notes
// [R1] program must issue mask-set command before any counting or interrupt happens
// [R2] each mask-set setting is latched on one issue and stays in effect
// [R3] program should issue each command once, on a rising condition
// [R4] after reset every input counts rising edges
// [R5] program may skip edge select when rising edges are wanted
// [R6] configuration is edge select then direction/enable for the same input
// [R7] inputs 0..7 dispatch interrupt tasks 140..147 when count condition met
// [R8] every interrupt task program ends with a task-end instruction
// [R9] reduced-I/O variant has no input interrupts 2 and 3
// [R10] edge 0 rising 1 falling; enable 2 down, 3 up; selectors 110-117, 100-107
// [R11] each input counts selected edges, fires its task when count reaches set value
// [R12] count direction selectable up or down by the mask-set command
// [R13] combined input pulse rate across all inputs stays at or below 5 kHz
// [R14] 16-bit set value per input plus separate present-value word
package edge_count_pkg;

    localparam int NUM_INPUTS = 8;
    localparam int COUNT_W = 16;
    localparam int TASK_W = 8;

    // command selector and operand encodings
    localparam logic [7:0] SEL_EDGE_BASE = 8'h6e;   // 110
    localparam logic [7:0] SEL_ENABLE_BASE = 8'h64; // 100
    localparam logic [15:0] OP_EDGE_RISE = 16'h0000;
    localparam logic [15:0] OP_EDGE_FALL = 16'h0001;
    localparam logic [15:0] OP_START_DOWN = 16'h0002;
    localparam logic [15:0] OP_START_UP = 16'h0003;
    localparam logic [7:0] TASK_BASE = 8'h8c;       // task 140

    // reset values
    localparam logic RST_EDGE_FALL = 1'b0;          // rising by default
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_COUNT_UP = 1'b0;
    localparam logic [15:0] RST_PRESENT = 16'h0000;

    // mask-set command as issued by the controlling program
    typedef struct packed {
        logic [7:0] selector;
        logic [15:0] operand;
    } mask_cmd_t;

    // task dispatch toward the task scheduler
    typedef struct packed {
        logic valid;
        logic [7:0] task_num;
    } task_req_t;

endpackage : edge_count_pkg

// [edge_channel.sv]
// edge_channel: one counter-mode input, edge detect, count and match
// assumes: input already synchronised to core_clk, config held by the parent
`timescale 1ns/10ps
`default_nettype none
module edge_channel
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // configuration
    input wire logic edge_fall,
    input wire logic count_up,
    input wire logic enable,
    input wire logic restart,
    input wire logic [15:0] set_value,
    // pin level, synchronised
    input wire logic pin_sync,
    // results
    output logic [15:0] present,
    output logic hit
);

    logic prev_pin;
    logic [15:0] next_present;
    logic next_prev_pin;
    logic next_hit;
    logic edge_seen;

    // edge detect, count and compare to set value
    always_comb
    begin
        next_prev_pin = pin_sync;
        edge_seen = edge_fall ? (prev_pin & ~pin_sync) : (~prev_pin & pin_sync); // R4
        next_present = present;
        next_hit = 1'b0;
        if (restart)
        begin
            next_present = edge_count_pkg::RST_PRESENT;
        end
        else if (enable && edge_seen)
        begin
            next_present = count_up ? present + 16'h0001 : present - 16'h0001; // R12
            if (next_present == set_value) // R11
            begin
                next_hit = 1'b1;
                next_present = edge_count_pkg::RST_PRESENT;
            end
        end
    end

    // registers only; all state frozen while clk_en is low
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_pin <= 1'b0;
            present <= edge_count_pkg::RST_PRESENT;
            hit <= 1'b0;
        end
        else if (clk_en)
        begin
            prev_pin <= next_prev_pin;
            present <= next_present;
            hit <= next_hit;
        end
    end

endmodule // edge_channel
`default_nettype wire

// [edge_count_asserts.sv]
// edge_count_asserts: port checks for the counter-mode input interrupt unit
// assumes: bound to edge_count_input_interrupt, single clock domain
`timescale 1ns/10ps
`default_nettype none
module edge_count_asserts
#(
    parameter bit REDUCED_IO = 1'b0
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // command
    input wire logic cmd_valid,
    input wire edge_count_pkg::mask_cmd_t cmd,
    // counts and pins
    input wire logic [127:0] set_values,
    input wire logic [7:0] irq_pins,
    input wire logic [127:0] present_values,
    // results
    input wire edge_count_pkg::task_req_t task_req,
    input wire logic cmd_error
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // command taken this edge
    wire logic go = cmd_valid & clk_en;
    ////////////////////////////////////////////////////////////////////////
    // dispatch and counting
    task_range_a: assert property (task_req.valid |-> task_req.task_num inside {[8'h8c:8'h93]})
        else $error("task number out of range");
    task_match_a: assert property (task_req.valid |->
        present_values[(task_req.task_num - 8'h8c) * 16 +: 16] == 16'h0000)
        else $error("count not restarted at dispatch");
    reset_zero_a: assert property ($rose(rst_n) |-> present_values == '0 && !task_req.valid)
        else $error("outputs not cleared after reset");
    // command answers
    err_cause_a: assert property (cmd_error && $past(clk_en) |-> $past(go))
        else $error("error without command");
    bad_sel_a: assert property (go &&
        !(cmd.selector inside {[8'h64:8'h6b], [8'h6e:8'h75]}) |=> cmd_error)
        else $error("bad selector accepted");
    no_chan_a: assert property (go && REDUCED_IO &&
        cmd.selector inside {8'h66, 8'h67, 8'h70, 8'h71} |=> cmd_error)
        else $error("absent input accepted");
    good_en_a: assert property (go &&
        cmd.selector inside {8'h64, 8'h65, [8'h68:8'h6b]}
        && cmd.operand inside {16'h0002, 16'h0003} |=> !cmd_error)
        else $error("valid enable refused");
    good_edge_a: assert property (go &&
        cmd.selector inside {8'h6e, 8'h6f, [8'h72:8'h75]}
        && cmd.operand[15:1] == 15'h0000 |=> !cmd_error)
        else $error("valid edge select refused");
endmodule // edge_count_asserts
bind edge_count_input_interrupt edge_count_asserts #(.REDUCED_IO(REDUCED_IO)) u_edge_count_asserts
(
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
    .set_values(set_values), .irq_pins(irq_pins), .present_values(present_values),
    .task_req(task_req), .cmd_error(cmd_error)
);
`default_nettype wire

// [pulse_source.sv]
// pulse_source: external pulse devices on the interrupt input pins
// assumes: pins are plain driven levels, changed at the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module pulse_source
(
    // clock
    input wire logic core_clk,
    // pins
    output logic [7:0] irq_pins
);
    initial irq_pins = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // one level change, then hold; spacing scaled down to keep runs short
    task automatic drive(input int ch, input logic lvl);
        @(negedge core_clk);
        irq_pins[ch] = lvl;
        repeat (8) @(negedge core_clk);
    endtask
    // full pulse: rise then fall
    task automatic pulse(input int ch, input int n);
        repeat (n)
        begin
            drive(ch, 1'b1);
            drive(ch, 1'b0);
        end
    endtask
endmodule // pulse_source
`default_nettype wire

// [edge_count_input_interrupt_tb.sv]
// edge_count_input_interrupt_tb: scenarios for the counter-mode input unit
// assumes: reduced variant, pulse_source drives the pins
`timescale 1ns/10ps
`default_nettype none
module edge_count_input_interrupt_tb;
    logic core_clk, rst_n, clk_en, cmd_valid, cmd_error;
    edge_count_pkg::mask_cmd_t cmd;
    edge_count_pkg::task_req_t task_req;
    logic [127:0] set_values, present_values;
    logic [7:0] irq_pins, last_task;
    int n_mismatch, n_checks, n_task, n_err, t0;
    edge_count_input_interrupt #(.REDUCED_IO(1'b1)) u_edge_count_input_interrupt (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd),
        .set_values(set_values), .irq_pins(irq_pins), .present_values(present_values),
        .task_req(task_req), .cmd_error(cmd_error));
    pulse_source u_pulse_source (.core_clk(core_clk), .irq_pins(irq_pins));
    ////////////////////////////////////////////////////////////////////////
    // clock and monitors
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // scheduler model: each dispatched task is taken as run to its end at once
    always @(posedge core_clk)
    begin
        if (task_req.valid === 1'b1) last_task = task_req.task_num;
        if (task_req.valid === 1'b1) n_task++;
        if (cmd_error === 1'b1) n_err++;
    end
    // compare and report
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask
    // one command pulse, then settle
    task automatic send(input logic [7:0] sel, input logic [15:0] op);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd = '{sel, op};
        @(negedge core_clk);
        cmd_valid = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_up();
        set_values[15:0] = 16'h0003;
        send(8'h64, 16'h0003);
        t0 = n_task;
        u_pulse_source.pulse(0, 2);
        check(present_values[15:0], 16'h0002);
        check(n_task - t0, 0);
        u_pulse_source.pulse(0, 1);
        check(n_task - t0, 1);
        check(last_task, 8'h8c);
    endtask
    task automatic t_fall();
        set_values[31:16] = 16'h0002;
        send(8'h6f, 16'h0001);
        send(8'h65, 16'h0003);
        u_pulse_source.drive(1, 1'b1);
        check(present_values[31:16], 16'h0000);
        u_pulse_source.drive(1, 1'b0);
        check(present_values[31:16], 16'h0001);
    endtask
    task automatic t_down();
        set_values[79:64] = 16'hfffe;
        send(8'h68, 16'h0002);
        u_pulse_source.pulse(4, 1);
        check(present_values[79:64], 16'hffff);
        u_pulse_source.pulse(4, 1);
        check(last_task, 8'h90);
        check(present_values[79:64], 16'h0000);
    endtask
    task automatic t_all();
        for (int i = 0; i < 8; i++)
        begin
            t0 = n_err;
            set_values[16 * i +: 16] = 16'h0001;
            send(8'h64 + 8'(i), 16'h0003);
            if (i == 2 || i == 3) check(n_err - t0, 1);
            if (i == 2 || i == 3) continue;
            u_pulse_source.pulse(i, 1);
            check(last_task, 8'h8c + 8'(i));
        end
    endtask
    task automatic t_bad();
        t0 = n_err;
        send(8'h63, 16'h0003);
        send(8'h6e, 16'h0005);
        send(8'h76, 16'h0000);
        check(n_err - t0, 3);
    endtask
    // no command yet: pulses on input 5 neither count nor dispatch
    task automatic t_idle();
        set_values[95:80] = 16'h0001;
        u_pulse_source.pulse(5, 1);
        check(present_values[95:80], 16'h0000);
        check(n_task, 0);
    endtask
    // clock enable low: a full pulse on input 0 leaves no trace
    task automatic t_freeze();
        t0 = n_task;
        @(negedge core_clk);
        clk_en = 1'b0;
        u_pulse_source.pulse(0, 1);
        clk_en = 1'b1;
        repeat (8) @(negedge core_clk);
        check(n_task - t0, 0);
        check(present_values[15:0], 16'h0000);
        u_pulse_source.pulse(0, 1);
        check(last_task, 8'h8c);
    endtask
    // reset mid-run: input 1 back to rising, then falling and rising selected again
    task automatic t_reset();
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        check(present_values, 128'h0);
        set_values[31:16] = 16'h0002;
        send(8'h65, 16'h0003);
        u_pulse_source.pulse(1, 1);
        check(present_values[31:16], 16'h0001);
        send(8'h6f, 16'h0001);
        send(8'h6f, 16'h0000);
        u_pulse_source.drive(1, 1'b1);
        check(last_task, 8'h8d);
        check(present_values[31:16], 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        cmd_valid = 1'b0;
        clk_en = 1'b1;
        cmd = '0;
        set_values = '0;
        rst_n = 1'b0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        t_idle();
        t_up();
        t_fall();
        t_down();
        t_all();
        t_freeze();
        t_bad();
        t_reset();
        results();
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
endmodule // edge_count_input_interrupt_tb
`default_nettype wire
